// ### src/smb_ext_regs.svh
`ifndef SMB_EXT_REGS_SVH
`define SMB_EXT_REGS_SVH

// Reference clock rate, used to turn times into cycle counts
`define REF_CLK_KHZ         250000
// Alert response address byte (address 0001100, read)
`define ARA_BYTE            8'h19
// General call address byte with the write bit
`define GC_BYTE             8'h00
// General call commands
`define GC_CMD_RELATCH      8'h04
`define GC_CMD_RESET        8'h06
// Fixed upper nibble of the seven-bit bus address
`define DEV_ADDR_PREFIX     4'h9
// Cycles after reset before the strap synchroniser holds real levels
`define STRAP_SETTLE        2'h2
// Last bit index of a byte
`define LAST_BIT            3'h7
// Stuck-clock window in ms
`define BUS_STUCK_MIN_MS    25
`define BUS_STUCK_MAX_MS    75
// Settle time of the reset sequence in us
`define SETTLE_US           500
// Register copy geometry
`define NUM_NV_REGS         4
`define NV_DATA_W           16

`endif

// ### src/smb_ext_pkg.sv
package smb_ext_pkg;

	// Serial engine states
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_ADDR   = 3'b001,
		ST_ACK    = 3'b010,
		ST_CMD    = 3'b011,
		ST_TX     = 3'b100,
		ST_TX_END = 3'b101,
		ST_SKIP   = 3'b110
	} link_state_t;

	// All state of the serial engine
	typedef struct packed {
		link_state_t state;
		link_state_t after_ack;
		logic        ack_phase;
		logic [7:0]  shift;
		logic [2:0]  bit_cnt;
		logic        sda_drive;
		logic        scl_d;
		logic        sda_d;
		logic [31:0] low_cnt;
		logic        alert_pend;
		logic        alert_high;
		logic [6:0]  bus_addr;
		logic        strap_loaded;
		logic [1:0]  strap_wait;
		logic        own_sel;
		logic        copy_start;
		logic        alert_drive;
	} engine_t;

endpackage

// ### src/sync2.sv
// Two-flop synchroniser; the first stage feeds only the second
module sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk,   // Destination clock
	input  wire logic         reset, // Async reset, active high
	input  wire logic [W-1:0] d,     // Level from another domain
	output logic      [W-1:0] q      // Synchronised level
);
	logic [W-1:0] meta_ff;

	// Both stages clear to zero
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			meta_ff <= '0;
			q       <= '0;
		end else begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end
endmodule

// ### src/nv_reg_copy.sv
`include "smb_ext_regs.svh"
// Copies each nonvolatile register into its volatile twin, one per cycle
module nv_reg_copy #(
	parameter int NREGS      = `NUM_NV_REGS,
	parameter int DW         = `NV_DATA_W,
	parameter int SETTLE_CYC = `SETTLE_US * (`REF_CLK_KHZ / 1000)
) (
	input  wire logic                     ref_clk,    // Block clock
	input  wire logic                     reset,      // Async reset
	input  wire logic                     clk_en,     // Freezes state when low
	input  wire logic                     start,      // One-cycle start pulse
	output logic      [$clog2(NREGS)-1:0] rd_idx,     // Nonvolatile read index
	input  wire logic [DW-1:0]            rd_data,    // Nonvolatile read data
	output logic                          wr_en,      // Volatile write strobe
	output logic      [$clog2(NREGS)-1:0] wr_idx,     // Volatile write index
	output logic      [DW-1:0]            wr_data,    // Volatile write data
	output logic                          busy        // Copy in progress
);
	localparam int IW = $clog2(NREGS);
	localparam logic [IW-1:0] LAST_IDX = IW'(NREGS - 1);
	localparam logic [31:0]   SETTLE   = 32'(SETTLE_CYC);

	typedef struct packed {
		logic          busy;
		logic [IW-1:0] idx;
		logic          wr_en;
		logic [IW-1:0] wr_idx;
		logic [DW-1:0] wr_data;
		logic [31:0]   elapsed;
	} copy_t;

	copy_t r_ff, nxt_r;

	// copy walk
	// Bounded by the settle time so busy can never outlast it
	always_comb begin
		nxt_r       = r_ff;
		nxt_r.wr_en = 1'b0;
		if (r_ff.busy) begin
			nxt_r.wr_en   = 1'b1;
			nxt_r.wr_idx  = r_ff.idx;
			nxt_r.wr_data = rd_data;
			nxt_r.idx     = r_ff.idx + IW'(1);
			nxt_r.elapsed = r_ff.elapsed + 32'h1;
			if (r_ff.idx == LAST_IDX || r_ff.elapsed >= SETTLE - 32'h1) begin
				nxt_r.busy = 1'b0;
			end
		end else if (start) begin
			nxt_r.busy    = 1'b1;
			nxt_r.idx     = '0;
			nxt_r.elapsed = 32'h0;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			r_ff <= '0;
		end else if (clk_en) begin
			r_ff <= nxt_r;
		end
	end

	assign rd_idx  = r_ff.idx;
	assign wr_en   = r_ff.wr_en;
	assign wr_idx  = r_ff.wr_idx;
	assign wr_data = r_ff.wr_data;
	assign busy    = r_ff.busy;
endmodule

// ### src/smb_ext_slave.sv
`include "smb_ext_regs.svh"
////////////////////////////////////////////////////////////////////////////////
module smb_ext_slave
	import smb_ext_pkg::*;
#(
	parameter int STUCK_CYC = `BUS_STUCK_MIN_MS * `REF_CLK_KHZ,
	parameter int NREGS     = `NUM_NV_REGS,
	parameter int DW        = `NV_DATA_W
) (
	input  wire logic                     ref_clk,                // Block clock
	input  wire logic                     reset,                  // Async reset, high
	input  wire logic                     clk_en,                 // Freezes state when low
	input  wire logic                     link_clk,               // Bus sampling clock
	input  wire logic                     scl_i,                  // Clock pin level
	input  wire logic                     sda_i,                  // Data pin level
	output logic                          sda_o,                  // Data pin drive value
	output logic                          sda_oe,                 // High pulls data low
	input  wire logic [2:0]               address_strap_pins,     // Address strap levels
	input  wire logic                     alarm_interrupt_select, // Interrupt mode
	input  wire logic                     alert_polarity,         // Zero selects active low
	input  wire logic                     alarm_event,            // Alarm pulse
	input  wire logic                     alarm_high_limit,       // Alarm from high limit
	output logic                          alert_o,                // Alert pin drive value
	output logic                          alert_oe,               // High pulls alert low
	output logic                          own_addr_sel,           // Own address accepted
	output logic      [6:0]               bus_addr,               // Active bus address
	output logic                          busy,                   // Reset copy running
	output logic      [$clog2(NREGS)-1:0] nv_rd_idx,              // Nonvolatile index
	input  wire logic [DW-1:0]            nv_rd_data,             // Nonvolatile data
	output logic                          vol_wr_en,              // Volatile write strobe
	output logic      [$clog2(NREGS)-1:0] vol_wr_idx,             // Volatile index
	output logic      [DW-1:0]            vol_wr_data             // Volatile data
);
	import smb_ext_pkg::*;

	// stuck window
	// Fires just past the minimum, far inside the maximum
	localparam logic [31:0] STUCK = 32'(STUCK_CYC);

	////////////////////////////////////////////////////////////////////////////
	// Link domain: pins sampled on the bus clock, drive retimed out

	logic [1:0] pins_link;
	logic [1:0] pins_ref;
	logic [2:0] strap_sync;
	logic       drive_link;
	engine_t    e_ff;
	engine_t    nxt_e;

	// Pin levels enter on the link clock
	sync2 #(.W(2)) u_pin_in (
		.clk   (link_clk),
		.reset (reset),
		.d     ({scl_i, sda_i}),
		.q     (pins_link)
	);

	// Levels then cross into the block clock
	sync2 #(.W(2)) u_pin_xing (
		.clk   (ref_clk),
		.reset (reset),
		.d     (pins_link),
		.q     (pins_ref)
	);

	// Data drive crosses back as a level
	sync2 #(.W(1)) u_drive_out (
		.clk   (link_clk),
		.reset (reset),
		.d     (e_ff.sda_drive),
		.q     (drive_link)
	);

	// Straps are pins too
	sync2 #(.W(3)) u_strap (
		.clk   (ref_clk),
		.reset (reset),
		.d     (address_strap_pins),
		.q     (strap_sync)
	);

	// Open-drain data: only ever pulled low
	assign sda_o  = 1'b0;
	assign sda_oe = drive_link;

	////////////////////////////////////////////////////////////////////////////
	// Reset copy engine

	logic copy_busy;

	nv_reg_copy #(
		.NREGS (NREGS),
		.DW    (DW)
	) u_copy (
		.ref_clk (ref_clk),
		.reset   (reset),
		.clk_en  (clk_en),
		.start   (e_ff.copy_start),
		.rd_idx  (nv_rd_idx),
		.rd_data (nv_rd_data),
		.wr_en   (vol_wr_en),
		.wr_idx  (vol_wr_idx),
		.wr_data (vol_wr_data),
		.busy    (copy_busy)
	);

	////////////////////////////////////////////////////////////////////////////
	// Serial engine

	// Bus address from the fixed prefix and strap levels
	function automatic logic [6:0] make_addr(input logic [2:0] straps);
		make_addr = {`DEV_ADDR_PREFIX, straps};
	endfunction

	// Start the acknowledge slot for the byte just taken
	function automatic engine_t begin_ack(input engine_t e, input link_state_t nxt_st);
		engine_t t;
		t           = e;
		t.state     = ST_ACK;
		t.after_ack = nxt_st;
		t.ack_phase = 1'b0;
		begin_ack   = t;
	endfunction

	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic smbus_mode;
	logic byte_done;
	logic [7:0] rx_byte;

	assign scl        = pins_ref[1];
	assign sda        = pins_ref[0];
	assign scl_rise   = scl & ~e_ff.scl_d;
	assign scl_fall   = ~scl & e_ff.scl_d;
	assign start_cond = scl & e_ff.scl_d & e_ff.sda_d & ~sda;
	assign stop_cond  = scl & e_ff.scl_d & ~e_ff.sda_d & sda;
	assign rx_byte    = {e_ff.shift[6:0], sda};
	assign byte_done  = scl_rise && e_ff.bit_cnt == `LAST_BIT;

	assign smbus_mode = alarm_interrupt_select & ~alert_polarity;

	always_comb begin
		nxt_e            = e_ff;
		nxt_e.scl_d      = scl;
		nxt_e.sda_d      = sda;
		nxt_e.copy_start = 1'b0;

		// Straps caught after reset release, once the synchroniser has
		// flushed its cleared stages; an earlier catch would latch zeros
		if (!e_ff.strap_loaded) begin
			nxt_e.bus_addr   = make_addr(strap_sync);
			nxt_e.strap_wait = e_ff.strap_wait + 2'h1;
			if (e_ff.strap_wait == `STRAP_SETTLE) begin
				nxt_e.strap_loaded = 1'b1;
			end
		end

		if (scl) begin
			nxt_e.low_cnt = 32'h0;
		end else if (e_ff.low_cnt < STUCK) begin
			nxt_e.low_cnt = e_ff.low_cnt + 32'h1;
		end

		case (e_ff.state)
			ST_ADDR, ST_CMD: begin
				if (scl_rise) begin
					nxt_e.shift   = rx_byte;
					nxt_e.bit_cnt = e_ff.bit_cnt + 3'h1;
				end
				if (byte_done && e_ff.state == ST_ADDR) begin
					nxt_e.state = ST_SKIP;
					if (rx_byte == `ARA_BYTE && smbus_mode && e_ff.alert_pend) begin
						nxt_e = begin_ack(nxt_e, ST_TX);
					end else if (rx_byte == `GC_BYTE) begin
						nxt_e = begin_ack(nxt_e, ST_CMD);
					end else if (rx_byte[7:1] == e_ff.bus_addr && !copy_busy) begin
						nxt_e         = begin_ack(nxt_e, ST_SKIP);
						nxt_e.own_sel = 1'b1;
					end
				end else if (byte_done) begin
					nxt_e.state = ST_SKIP;
					if (rx_byte == `GC_CMD_RELATCH) begin
						nxt_e          = begin_ack(nxt_e, ST_SKIP);
						nxt_e.bus_addr = make_addr(strap_sync);
					end else if (rx_byte == `GC_CMD_RESET) begin
						nxt_e            = begin_ack(nxt_e, ST_SKIP);
						nxt_e.bus_addr   = make_addr(strap_sync);
						nxt_e.copy_start = 1'b1;
					end
				end
			end
			ST_ACK: begin
				// Pull low for one bit time, fall to fall
				if (scl_fall && !e_ff.ack_phase) begin
					nxt_e.sda_drive = 1'b1;
					nxt_e.ack_phase = 1'b1;
				end else if (scl_fall) begin
					nxt_e.sda_drive = 1'b0;
					nxt_e.bit_cnt   = 3'h0;
					nxt_e.state     = e_ff.after_ack;
					if (e_ff.after_ack == ST_TX) begin
						nxt_e.shift     = {e_ff.bus_addr, e_ff.alert_high};
						nxt_e.sda_drive = ~e_ff.bus_addr[6];
					end
				end
			end
			ST_TX: begin
				if (scl_rise) begin
					nxt_e.bit_cnt = e_ff.bit_cnt + 3'h1;
					if (!e_ff.sda_drive && !sda) begin
						nxt_e.sda_drive = 1'b0;
						nxt_e.state     = ST_SKIP;
					end else if (e_ff.bit_cnt == `LAST_BIT) begin
						nxt_e.state = ST_TX_END;
					end
				end else if (scl_fall) begin
					nxt_e.shift     = {e_ff.shift[6:0], 1'b0};
					nxt_e.sda_drive = ~e_ff.shift[6];
				end
			end
			ST_TX_END: begin
				// Whole address out: release the line
				if (scl_fall) begin
					nxt_e.sda_drive = 1'b0;
					nxt_e.state     = ST_SKIP;
				end
			end
			ST_IDLE, ST_SKIP: begin
				nxt_e.sda_drive = 1'b0;
			end
			default: begin
				nxt_e.state     = ST_IDLE;
				nxt_e.sda_drive = 1'b0;
			end
		endcase

		// Start, repeated or not, restarts address reception
		if (start_cond) begin
			nxt_e.state     = ST_ADDR;
			nxt_e.bit_cnt   = 3'h0;
			nxt_e.sda_drive = 1'b0;
			nxt_e.own_sel   = 1'b0;
		end else if (stop_cond) begin
			nxt_e.state     = ST_IDLE;
			nxt_e.sda_drive = 1'b0;
			nxt_e.own_sel   = 1'b0;
		end

		// idle right away, so a start is seen at once
		if (e_ff.low_cnt >= STUCK) begin
			nxt_e.state     = ST_IDLE;
			nxt_e.sda_drive = 1'b0;
			nxt_e.own_sel   = 1'b0;
			nxt_e.bit_cnt   = 3'h0;
		end

		// winner clears; a new alarm in the same cycle wins
		if (e_ff.state == ST_TX_END && scl_fall) begin
			nxt_e.alert_pend = 1'b0;
		end
		if (alarm_event) begin
			nxt_e.alert_pend = 1'b1;
			nxt_e.alert_high = alarm_high_limit;
		end

		// pin pulled low only in SMBus mode
		nxt_e.alert_drive = nxt_e.alert_pend & smbus_mode;
	end

	// Idle bus levels are high, so edge history starts high
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			e_ff           <= '0;
			e_ff.state     <= ST_IDLE;
			e_ff.after_ack <= ST_IDLE;
			e_ff.scl_d     <= 1'b1;
			e_ff.sda_d     <= 1'b1;
		end else if (clk_en) begin
			e_ff <= nxt_e;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign alert_o      = 1'b0;
	assign alert_oe     = e_ff.alert_drive;
	assign own_addr_sel = e_ff.own_sel;
	assign bus_addr     = e_ff.bus_addr;
	assign busy         = copy_busy;
endmodule

// ### tb/smb_master_model.sv
// Behavioural bus master: open-drain data, clock idles high outside frames
module smb_master_model (
	output logic      scl,     // Clock pin drive
	output logic      sda_low, // High pulls data low
	input  wire logic sda      // Resolved data wire
);
	timeunit 1ns;
	timeprecision 1ps;

	// Bus idle: clock high, data released
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// bit rate: 600 ns per bit keeps far above the timeout floor
	task automatic clk_bit(input logic b, output logic r);
		#150 sda_low = !b;
		#150 scl = 1'b1;
		#150 r = sda;
		#150 scl = 1'b0;
	endtask

	// Start: data falls while clock is high
	task automatic start_c();
		#300 sda_low = 1'b1;
		#300 scl = 1'b0;
	endtask

	// Stop: data rises while clock is high
	task automatic stop_c();
		#150 sda_low = 1'b1;
		#150 scl = 1'b1;
		#300 sda_low = 1'b0;
		#300;
	endtask

	// Releases data and holds the clock low as a stalled master would
	task automatic rest(input int ns);
		#150 sda_low = 1'b0;
		#(ns);
	endtask

	// byte send, MSB first, ack read on the ninth clock
	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
		clk_bit(1'b1, r);
		ack = !r;
	endtask

	// Byte receive; master answers with a nack
	task automatic get_byte(output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
		clk_bit(1'b1, r);
	endtask
endmodule

// ### tb/smb_ext_slave_chk.sv
// Port-level checks of the alert, timeout and reset-copy behaviour
module smb_ext_slave_chk #(
	parameter int STUCK_CYC = 2000,
	parameter int NREGS     = 4,
	parameter int DW        = 16
) (
	input wire logic                     ref_clk,                // Block clock
	input wire logic                     reset,                  // Async reset
	input wire logic                     scl_i,                  // Clock pin
	input wire logic                     sda_oe,                 // Data pull
	input wire logic                     alarm_interrupt_select, // Interrupt mode
	input wire logic                     alert_polarity,         // Polarity
	input wire logic                     alarm_event,            // Alarm pulse
	input wire logic                     alert_oe,               // Alert pull
	input wire logic                     own_addr_sel,           // Own address
	input wire logic [6:0]               bus_addr,               // Active address
	input wire logic                     busy,                   // Copy running
	input wire logic [$clog2(NREGS)-1:0] nv_rd_idx,              // Read index
	input wire logic [DW-1:0]            nv_rd_data,             // Read data
	input wire logic                     vol_wr_en,              // Write strobe
	input wire logic [$clog2(NREGS)-1:0] vol_wr_idx,             // Write index
	input wire logic [DW-1:0]            vol_wr_data             // Write data
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);

	// Cycles the clock pin has stayed low, sampled coarsely on ref_clk
	int unsigned low_ff;
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			low_ff <= 0;
		end else begin
			low_ff <= scl_i ? 0 : low_ff + 1;
		end
	end

	alert_off_a: assert property ((!alarm_interrupt_select || alert_polarity) |=> !alert_oe)
		else $error("alert driven outside interrupt active-low mode");
	alert_set_a: assert property (alarm_event && alarm_interrupt_select && !alert_polarity
		|=> alert_oe)
		else $error("alert not driven after alarm");
	addr_prefix_a: assert property (!$past(reset) |-> bus_addr[6:3] == 4'h9)
		else $error("bus address prefix wrong");
	// Margin covers the three synchroniser chains
	stuck_free_a: assert property (low_ff > STUCK_CYC + 64 |-> !sda_oe)
		else $error("data still driven after stuck clock");
	// Repetition count matches the four registers of this build
	copy_len_a: assert property ($rose(busy) |-> busy [*4] ##1 !busy)
		else $error("copy busy length wrong");
	copy_order_a: assert property ($rose(busy) |=> vol_wr_en && vol_wr_idx == 0)
		else $error("copy does not start at index zero");
	copy_data_a: assert property (vol_wr_en |-> vol_wr_idx == $past(nv_rd_idx)
		&& vol_wr_data == $past(nv_rd_data))
		else $error("copied data does not match source");
	copy_run_a: assert property ($rose(busy) |=> vol_wr_en [*4] ##1 !vol_wr_en)
		else $error("copy strobes not consecutive");
	no_sel_busy_a: assert property (busy |=> !$rose(own_addr_sel))
		else $error("own address taken during copy");

	cover property ($rose(busy));
	cover property ($fell(alert_oe));
	cover property (low_ff == STUCK_CYC + 65);
endmodule

bind smb_ext_slave smb_ext_slave_chk #(.STUCK_CYC(STUCK_CYC), .NREGS(NREGS), .DW(DW))
	u_smb_ext_slave_chk (.ref_clk, .reset, .scl_i, .sda_oe, .alarm_interrupt_select,
	.alert_polarity, .alarm_event, .alert_oe, .own_addr_sel, .bus_addr, .busy, .nv_rd_idx,
	.nv_rd_data, .vol_wr_en, .vol_wr_idx, .vol_wr_data);

// ### tb/smb_ext_slave_test.sv
`include "smb_ext_regs.svh"
module smb_ext_slave_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int STUCK = 2000;
	logic ref_clk = 0, link_clk = 0, reset = 1, rival_low = 0, alarm_event = 0;
	logic alarm_high_limit = 0, alarm_interrupt_select = 1, alert_polarity = 0;
	logic [2:0] address_strap_pins = 3'h5;
	logic scl_i, sda_low, sda_oe, alert_oe, busy, vol_wr_en, ack;
	logic [6:0] bus_addr;
	logic [1:0] nv_rd_idx, vol_wr_idx;
	logic [15:0] vol_wr_data;
	logic [7:0] d;
	int n_fail = 0, check_count = 0;
	// Open-drain data wire with pull-up; a rival slave may pull it too
	wire logic sda_i = !(sda_oe || sda_low || rival_low);
	wire logic [15:0] nv_rd_data = {14'h1a5, nv_rd_idx};

	always #2 ref_clk = !ref_clk;
	always #3 link_clk = !link_clk;

	smb_ext_slave #(.STUCK_CYC(STUCK)) u_smb_ext_slave (
		.ref_clk, .reset, .clk_en(1'b1), .link_clk, .scl_i, .sda_i, .sda_o(), .sda_oe,
		.address_strap_pins, .alarm_interrupt_select, .alert_polarity, .alarm_event,
		.alarm_high_limit, .alert_o(), .alert_oe, .own_addr_sel(), .bus_addr, .busy,
		.nv_rd_idx, .nv_rd_data, .vol_wr_en, .vol_wr_idx, .vol_wr_data);
	smb_master_model u_smb_master_model (.scl(scl_i), .sda_low, .sda(sda_i));

	task automatic tick(input int n = 1);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic print_verdict();
		if (n_fail == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic raise(input logic hi);
		alarm_high_limit = hi;
		alarm_event = 1'b1;
		tick();
		alarm_event = 1'b0;
		tick(2);
	endtask

	task automatic ara(input logic exp_ack);
		u_smb_master_model.start_c();
		u_smb_master_model.put_byte(`ARA_BYTE, ack);
		check("ara ack", exp_ack, ack);
	endtask

	task automatic t_alert_high();
		raise(1'b1);
		check("alert_oe", 1, alert_oe);
		ara(1'b1);
		u_smb_master_model.get_byte(d);
		u_smb_master_model.stop_c();
		check("ara addr", {8'h0, 4'h9, address_strap_pins, 1'b1}, d);
		check("alert after win", 0, alert_oe);
	endtask

	// Lost arbitration must leave the alert pending for the next read
	task automatic t_arbitration();
		alert_polarity = 1'b1;
		raise(1'b0);
		check("alert_oe pol", 0, alert_oe);
		ara(1'b0);
		u_smb_master_model.stop_c();
		alert_polarity = 1'b0;
		tick(2);
		check("alert pending", 1, alert_oe);
		ara(1'b1);
		rival_low = 1'b1;
		u_smb_master_model.get_byte(d);
		rival_low = 1'b0;
		u_smb_master_model.stop_c();
		check("alert after loss", 1, alert_oe);
		ara(1'b1);
		u_smb_master_model.get_byte(d);
		u_smb_master_model.stop_c();
		check("ara addr low", {8'h0, 4'h9, address_strap_pins, 1'b0}, d);
		check("alert cleared", 0, alert_oe);
	endtask

	task automatic t_gencall();
		u_smb_master_model.start_c();
		u_smb_master_model.put_byte(8'h01, ack);
		check("gc read ack", 0, ack);
		u_smb_master_model.stop_c();
		u_smb_master_model.start_c();
		u_smb_master_model.put_byte(`GC_BYTE, ack);
		check("gc ack", 1, ack);
		address_strap_pins = 3'h2;
		u_smb_master_model.put_byte(`GC_CMD_RELATCH, ack);
		u_smb_master_model.stop_c();
		check("relatch ack", 1, ack);
		check("relatch addr", {9'h0, 4'h9, 3'h2}, bus_addr);
	endtask

	task automatic t_gcreset();
		int i;
		address_strap_pins = 3'h3;
		u_smb_master_model.start_c();
		u_smb_master_model.put_byte(`GC_BYTE, ack);
		fork
			u_smb_master_model.put_byte(`GC_CMD_RESET, ack);
			begin
				for (i = 0; i < 3000 && busy !== 1'b1; i++) tick();
				tick();
				for (i = 0; i < 4; i++) begin
					check("wr_en", 1, vol_wr_en);
					check("wr_data", {14'h1a5, i[1:0]}, vol_wr_data);
					tick();
				end
				check("busy end", 0, busy);
			end
		join
		u_smb_master_model.stop_c();
		check("reset ack", 1, ack);
		check("reset addr", {9'h0, 4'h9, 3'h3}, bus_addr);
	endtask

	// Stall inside the ack of the own address until the stuck window runs out
	task automatic t_timeout();
		logic r;
		d = {4'h9, address_strap_pins, 1'b0};
		u_smb_master_model.start_c();
		for (int i = 7; i >= 0; i--) u_smb_master_model.clk_bit(d[i], r);
		u_smb_master_model.rest(100);
		check("own ack", 1, sda_oe);
		u_smb_master_model.rest(STUCK * 4 + 600);
		check("sda freed", 0, sda_oe);
		u_smb_master_model.stop_c();
		u_smb_master_model.start_c();
		u_smb_master_model.put_byte(d, ack);
		u_smb_master_model.stop_c();
		check("ack after timeout", 1, ack);
	endtask

	// Watchdog well beyond the expected run of about 100 us
	initial begin
		#350us;
		n_fail++;
		print_verdict();
	end

	// Main sequence
	initial begin
		repeat (6) @(posedge ref_clk);
		#1 reset = 1'b0;
		tick(12);
		check("reset addr", {9'h0, 4'h9, 3'h5}, bus_addr);
		t_alert_high();
		t_arbitration();
		t_gencall();
		t_gcreset();
		t_timeout();
		print_verdict();
	end
endmodule
